/* File: common/fault_resp_regs.svh */
`ifndef FAULT_RESP_REGS_SVH
`define FAULT_RESP_REGS_SVH

// bus geometry
`define FRM_ADDR_W        8
`define FRM_DATA_W        32
`define FRM_STATUS_W      12
`define FRM_EVENT_W       16

// register byte addresses
`define OFF_STATUS        8'h00
`define OFF_ALARM_MASK    8'h04
`define OFF_WARN_MASK     8'h08
`define OFF_FAILSAFE      8'h0c
`define OFF_IRQ_MASK      8'h10
`define OFF_STATE         8'h14

// status bit positions
`define ST_CLOCK_WATCH    0
`define ST_REG_PRI        1
`define ST_REG_SEC        2
`define ST_SERIAL         3
`define ST_SETUP_PRI      4
`define ST_SETUP_SEC      5
`define ST_CALIB_PRI      6
`define ST_CALIB_SEC      7
`define ST_SELFTEST_PRI   8
`define ST_SELFTEST_SEC   9
`define ST_COMM_PRI       10
`define ST_COMM_SEC       11

// which faults may reach the alarm, warning and gate outputs at all
`define ALARM_MAP         12'hfff
`define WARN_MAP          12'h3c8
`define ALWAYS_PL_MAP     12'h341
`define SELECT_PL_MAP     12'hcbe

// reset values
`define ALARM_MASK_RST    12'hbf7
`define WARN_MASK_RST     12'h3c8
`define FAILSAFE_RST      12'hcb6
`define IRQ_MASK_RST      12'h000

// state register fields
`define STATE_GATE_PL     0
`define STATE_SPI_EN      1
`define STATE_LOCK        2
`define STATE_ALARM       3
`define STATE_WARN        4

`endif

/* File: common/fault_pkg.sv */
package fault_pkg;

  typedef struct packed {
    logic clock_watch_sec;
    logic regulator_pri_uv;
    logic regulator_pri_ov;
    logic regulator_sec_uv;
    logic regulator_sec_ov;
    logic first_internal_regulator_ov;
    logic second_internal_regulator_ov;
    logic serial_clock_err;
    logic serial_addr_err;
    logic serial_crc_err;
    logic setup_crc_pri;
    logic setup_crc_sec;
    logic calib_crc_pri;
    logic calib_crc_sec;
    logic selftest_pri;
    logic selftest_sec;
  } fault_events_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic {
    GATE_NO_ACTION,
    GATE_PULL_LOW
  } gate_action_t;

endpackage

/* File: logic/pin_sync3.sv */
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

/* File: logic/sticky_bank.sv */
`timescale 1ns/10ps
module sticky_bank #(
  parameter int WIDTH = 12
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output logic      [WIDTH-1:0] q
);

  // set after clear: an event in the clearing cycle survives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= (q & ~clr_in) | set_in;
    end
  end

endmodule

/* File: logic/fault_response_manager.sv */
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "fault_resp_regs.svh"
// What this block does
// - secondary clock fault: flag, pull gate low, port stays on, alarm per mask
// - regulator under/over voltage: side flag, fail-safe pull low, port on, alarm
// - first regulator overvoltage: secondary link fault, port disabled, alarm
// - second regulator overvoltage: primary link fault, fail-safe pull low, alarm only per mask, port on
// - serial clock/address/crc faults share a flag; warning, alarm only per mask, selectable gate action
// - setup checksum mismatch: side flag, fail-safe pull low, alarm per mask
// - calibration checksum: primary always pulls low, secondary selectable; alarm and warning
// - self-test failure: side flag, pull low, alarm and warning per mask
// - gate actions are no action or pull low; port enabled or disabled
module fault_response_manager (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire fault_pkg::bus_req_t      bus,
  output logic [`FRM_DATA_W-1:0]        rdata,
  input  wire fault_pkg::fault_events_t fault_raw,
  output logic                          gate_pull_low,
  output logic                          serial_port_enable,
  output logic                          alarm_pin_n,
  output logic                          warning_pin_n,
  output logic                          irq
);

  logic [`FRM_EVENT_W-1:0]    fault_clean;
  fault_pkg::fault_events_t   ev;
  logic [`FRM_STATUS_W-1:0]   status_set;
  logic [`FRM_STATUS_W-1:0]   status_clr;
  logic [`FRM_STATUS_W-1:0]   status;
  logic [`FRM_STATUS_W-1:0]   alarm_mask_q;
  logic [`FRM_STATUS_W-1:0]   warn_mask_q;
  logic [`FRM_STATUS_W-1:0]   failsafe_q;
  logic [`FRM_STATUS_W-1:0]   irq_mask_q;
  logic                       port_lock_q;
  logic                       port_lock_d;
  fault_pkg::gate_action_t    gate_action_d;
  logic                       alarm_active;
  logic                       warn_active;
  logic                       irq_active;
  logic                       wr_status;
  logic                       wr_alarm_mask;
  logic                       wr_warn_mask;
  logic                       wr_failsafe;
  logic                       wr_irq_mask;
  logic [`FRM_DATA_W-1:0]     rdata_d;
  logic [`FRM_STATUS_W-1:0]   wr_field;
  logic                       reg_pri_event;
  logic                       reg_sec_event;
  logic                       serial_event;
  logic                       lock_event;
  logic                       always_pl_hit;
  logic                       select_pl_hit;
  logic [`FRM_STATUS_W-1:0]   select_pl_live;
  logic [`FRM_STATUS_W-1:0]   alarm_live;
  logic [`FRM_STATUS_W-1:0]   warn_live;
  logic [`FRM_DATA_W-1:0]     state_word;

  function automatic logic any_masked(
    input logic [`FRM_STATUS_W-1:0] vec,
    input logic [`FRM_STATUS_W-1:0] mask
  );
    return |(vec & mask);
  endfunction

  function automatic logic hit(
    input logic [`FRM_ADDR_W-1:0] addr,
    input logic [`FRM_ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction

  function automatic logic wr_hit(
    input fault_pkg::bus_req_t    req,
    input logic [`FRM_ADDR_W-1:0] offset
  );
    return req.wr && hit(req.addr, offset);
  endfunction

  // detectors sit in other supply and clock regions
  pin_sync3 #(
    .WIDTH (`FRM_EVENT_W)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (fault_raw),
    .dout  (fault_clean)
  );

  assign ev = fault_pkg::fault_events_t'(fault_clean);

  // register write decode
  assign wr_field      = bus.wdata[`FRM_STATUS_W-1:0];
  assign wr_status     = wr_hit(bus, `OFF_STATUS);
  assign wr_alarm_mask = wr_hit(bus, `OFF_ALARM_MASK);
  assign wr_warn_mask  = wr_hit(bus, `OFF_WARN_MASK);
  assign wr_failsafe   = wr_hit(bus, `OFF_FAILSAFE);
  assign wr_irq_mask   = wr_hit(bus, `OFF_IRQ_MASK);

  // both directions of a regulator excursion share that side's flag
  assign reg_pri_event = ev.regulator_pri_uv | ev.regulator_pri_ov;
  assign reg_sec_event = ev.regulator_sec_uv | ev.regulator_sec_ov;

  // the host cannot tell the three serial errors apart from the flag alone
  assign serial_event = ev.serial_clock_err
                      | ev.serial_addr_err
                      | ev.serial_crc_err;

  // fault to status mapping
  always_comb begin
    status_set = '0;
    status_set[`ST_CLOCK_WATCH] = ev.clock_watch_sec;
    status_set[`ST_REG_PRI] = reg_pri_event;
    status_set[`ST_REG_SEC] = reg_sec_event;
    status_set[`ST_SERIAL] = serial_event;
    // checksum and self-test faults keep one flag per side
    status_set[`ST_SETUP_PRI] = ev.setup_crc_pri;
    status_set[`ST_SETUP_SEC] = ev.setup_crc_sec;
    status_set[`ST_CALIB_PRI] = ev.calib_crc_pri;
    status_set[`ST_CALIB_SEC] = ev.calib_crc_sec;
    status_set[`ST_SELFTEST_PRI] = ev.selftest_pri;
    status_set[`ST_SELFTEST_SEC] = ev.selftest_sec;
    // regulator overvoltage has no flag of its own, only the link fault
    status_set[`ST_COMM_SEC] = ev.first_internal_regulator_ov;
    status_set[`ST_COMM_PRI] = ev.second_internal_regulator_ov;
  end

  // write one to clear; zero bits leave their flags alone
  assign status_clr = wr_status ? wr_field : '0;

  sticky_bank #(
    .WIDTH (`FRM_STATUS_W)
  ) u_status (
    .clock  (clock),
    .rst_n  (rst_n),
    .set_in (status_set),
    .clr_in (status_clr),
    .q      (status)
  );

  // configuration registers, one concern each
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_mask_q <= `ALARM_MASK_RST;
    end else if (wr_alarm_mask) begin
      alarm_mask_q <= wr_field;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      warn_mask_q <= `WARN_MASK_RST;
    end else if (wr_warn_mask) begin
      warn_mask_q <= wr_field;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      failsafe_q <= `FAILSAFE_RST;
    end else if (wr_failsafe) begin
      failsafe_q <= wr_field;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask_q <= `IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wr_field;
    end
  end

  // port lockout survives a status clear; only a power cycle (reset) lifts it
  assign lock_event  = ev.first_internal_regulator_ov;
  assign port_lock_d = port_lock_q | lock_event;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_lock_q <= 1'b0;
    end else begin
      port_lock_q <= port_lock_d;
    end
  end

  // every other fault leaves the port enabled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_port_enable <= 1'b1;
    end else begin
      serial_port_enable <= ~port_lock_d;
    end
  end

  // fail-safe bits outside the selectable set are ignored; fixed faults pull low regardless
  assign select_pl_live = failsafe_q & `SELECT_PL_MAP;
  assign always_pl_hit  = any_masked(status, `ALWAYS_PL_MAP);
  assign select_pl_hit  = any_masked(status, select_pl_live);

  // gate action: fixed pull-low faults plus fail-safe selected ones
  always_comb begin
    case ({always_pl_hit, select_pl_hit})
      2'h0: begin
        gate_action_d = fault_pkg::GATE_NO_ACTION;
      end
      default: begin
        gate_action_d = fault_pkg::GATE_PULL_LOW;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gate_pull_low <= 1'b0;
    end else begin
      gate_pull_low <= (gate_action_d == fault_pkg::GATE_PULL_LOW);
    end
  end

  // pins and interrupt; mask bits outside a pin's map cannot route a fault there
  assign alarm_live   = alarm_mask_q & `ALARM_MAP;
  assign warn_live    = warn_mask_q & `WARN_MAP;
  assign alarm_active = any_masked(status, alarm_live);
  assign warn_active  = any_masked(status, warn_live);
  assign irq_active   = any_masked(status, irq_mask_q);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_pin_n <= 1'b1;
    end else begin
      alarm_pin_n <= ~alarm_active;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      warning_pin_n <= 1'b1;
    end else begin
      warning_pin_n <= ~warn_active;
    end
  end

  // a level, not a pulse: stays up until the flag is cleared or masked
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_active;
    end
  end

  // snapshot of the gate, port, alarm and warning outputs and the port lock, read-only for software
  always_comb begin
    state_word                 = '0;
    state_word[`STATE_GATE_PL] = gate_pull_low;
    state_word[`STATE_SPI_EN]  = serial_port_enable;
    state_word[`STATE_LOCK]    = port_lock_q;
    state_word[`STATE_ALARM]   = ~alarm_pin_n;
    state_word[`STATE_WARN]    = ~warning_pin_n;
  end

  // read mux; unmapped offsets read zero, upper bits always zero
  always_comb begin
    rdata_d = '0;
    case (bus.addr)
      `OFF_STATUS: begin
        rdata_d[`FRM_STATUS_W-1:0] = status;
      end
      `OFF_ALARM_MASK: begin
        rdata_d[`FRM_STATUS_W-1:0] = alarm_mask_q;
      end
      `OFF_WARN_MASK: begin
        rdata_d[`FRM_STATUS_W-1:0] = warn_mask_q;
      end
      `OFF_FAILSAFE: begin
        rdata_d[`FRM_STATUS_W-1:0] = failsafe_q;
      end
      `OFF_IRQ_MASK: begin
        rdata_d[`FRM_STATUS_W-1:0] = irq_mask_q;
      end
      `OFF_STATE: begin
        rdata_d = state_word;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (bus.rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= '0;
    end
  end

endmodule

/* File: sim/fault_resp_monitor.sv */
`timescale 1ns/10ps
module fault_resp_monitor (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire fault_pkg::bus_req_t      bus,
  input wire logic [31:0]              rdata,
  input wire fault_pkg::fault_events_t fault_raw,
  input wire logic                     gate_pull_low,
  input wire logic                     serial_port_enable,
  input wire logic                     alarm_pin_n,
  input wire logic                     warning_pin_n,
  input wire logic                     irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // eight samples clear the sync and filter stages with margin
  sequence s_steady(logic x);
    x [*8];
  endsequence

  a_port_lock: assert property (s_steady(fault_raw.first_internal_regulator_ov) |-> ##1 !serial_port_enable)
    else $error("port still enabled after first regulator overvoltage");
  a_lock_holds: assert property (!serial_port_enable |=> !serial_port_enable)
    else $error("port lock released without reset");
  a_clock_pull: assert property (s_steady(fault_raw.clock_watch_sec) |-> ##1 gate_pull_low)
    else $error("gate not pulled low on clock watch fault");
  a_calib_pull: assert property (s_steady(fault_raw.calib_crc_pri) |-> ##1 gate_pull_low)
    else $error("gate not pulled low on primary calibration fault");
  a_selftest_pull: assert property (s_steady(fault_raw.selftest_pri || fault_raw.selftest_sec)
    |-> ##1 gate_pull_low)
    else $error("gate not pulled low on self-test fault");
  a_port_kept: assert property (
    s_steady(serial_port_enable && !fault_raw.first_internal_regulator_ov) |=> serial_port_enable)
    else $error("port disabled without first regulator overvoltage");
  a_read_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside the read answer cycle");
  a_pins_reset: assert property (disable iff (1'b0) !rst_n |=>
    alarm_pin_n && warning_pin_n && serial_port_enable && !gate_pull_low && !irq)
    else $error("outputs not idle after reset");
endmodule

bind fault_response_manager fault_resp_monitor mon (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .fault_raw(fault_raw), .gate_pull_low(gate_pull_low), .serial_port_enable(serial_port_enable),
  .alarm_pin_n(alarm_pin_n), .warning_pin_n(warning_pin_n), .irq(irq));

/* File: sim/host_model.sv */
`timescale 1ns/10ps
module host_model (
  input  wire logic                clock,
  input  wire logic [31:0]         rdata,
  output fault_pkg::bus_req_t      bus,
  output fault_pkg::fault_events_t fault_raw,
  output logic                     rst_n
);
  initial begin
    bus <= '0;
  end

  // reset stands for cycling both supplies; defaults return, so config is rewritten after
  task automatic power_cycle();
    fault_raw <= '0;
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  task automatic set_faults(input logic [15:0] v);
    fault_raw <= v;
  endtask

  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    // answer stands until this edge; read before the design's update lands
    @(posedge clock);
    d = rdata;
  endtask
endmodule

/* File: sim/fault_response_manager_tb_top.sv */
`timescale 1ns/10ps
`include "fault_resp_regs.svh"
module fault_response_manager_tb_top;
  logic                     clock = 1'b0;
  logic                     rst_n;
  fault_pkg::bus_req_t      bus;
  fault_pkg::fault_events_t fault_raw;
  logic [31:0]              rdata;
  logic                     gate, spe, alarm_n, warn_n, irq;
  int                       num_errors = 0;
  int                       checks_done = 0;
  int                       cycles = 0;

  always #12.5 clock = ~clock;

  host_model host (.clock(clock), .rdata(rdata), .bus(bus), .fault_raw(fault_raw), .rst_n(rst_n));
  fault_response_manager dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .fault_raw(fault_raw),
    .gate_pull_low(gate), .serial_port_enable(spe), .alarm_pin_n(alarm_n), .warning_pin_n(warn_n), .irq(irq));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // expected {gate, alarm_n, warn_n} for a status word under default fail-safe and warning masks
  function automatic logic [2:0] pins(input logic [11:0] st, input logic [11:0] am);
    pins[2] = |(st & (`ALWAYS_PL_MAP | (`FAILSAFE_RST & `SELECT_PL_MAP)));
    pins[1] = ~|(st & am & `ALARM_MAP);
    pins[0] = ~|(st & `WARN_MASK_RST & `WARN_MAP);
  endfunction

  task automatic t_each_fault();
    int          idx[16] = '{9, 8, 7, 6, 5, 4, 3, 3, 3, 10, 11, 2, 2, 1, 1, 0};
    logic [31:0] d;
    logic [11:0] st;
    for (int i = 0; i < 16; i++) begin
      host.power_cycle();
      host.set_faults(16'h1 << i);
      repeat (10) @(posedge clock);
      host.set_faults(16'h0);
      repeat (8) @(posedge clock);
      host.read(`OFF_STATUS, d);
      st = 12'h1 << idx[i];
      check("status", {20'h0, st}, d);
      check("pins", {29'h0, pins(st, `ALARM_MASK_RST)}, {29'h0, gate, alarm_n, warn_n});
      check("port", {31'h0, i != 10}, {31'h0, spe});
      host.read(`OFF_STATE, d);
      check("lock", {31'h0, i == 10}, {31'h0, d[`STATE_LOCK]});
    end
    $display("test each_fault done");
  endtask

  task automatic t_regs();
    logic [7:0]  offs[6] = '{`OFF_ALARM_MASK, `OFF_WARN_MASK, `OFF_FAILSAFE, `OFF_IRQ_MASK, `OFF_STATE, 8'h18};
    logic [11:0] rv[6] = '{`ALARM_MASK_RST, `WARN_MASK_RST, `FAILSAFE_RST, `IRQ_MASK_RST, 12'h002, 12'h000};
    logic [31:0] d;
    host.power_cycle();
    host.write(`OFF_STATE, 32'h1f);
    for (int i = 0; i < 6; i++) begin
      host.read(offs[i], d);
      check("reset value", {20'h0, rv[i]}, d);
    end
    host.write(`OFF_IRQ_MASK, 32'h200);
    host.set_faults(16'h0001);
    repeat (10) @(posedge clock);
    host.set_faults(16'h0);
    repeat (8) @(posedge clock);
    #1 check("irq pins", 32'hc, {28'h0, irq, gate, alarm_n, warn_n});
    host.write(`OFF_ALARM_MASK, 32'h0);
    host.write(`OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock);
    #1 check("masked", 32'h6, {28'h0, irq, gate, alarm_n, warn_n});
    host.write(`OFF_STATUS, 32'h200);
    repeat (2) @(posedge clock);
    #1 check("cleared", 32'h3, {28'h0, irq, gate, alarm_n, warn_n});
    // serial faults pull the gate only once their fail-safe bit is chosen
    host.write(`OFF_FAILSAFE, {20'h0, `SELECT_PL_MAP});
    host.set_faults(16'h0040);
    repeat (10) @(posedge clock);
    #1 check("serial gate", 32'h2, {30'h0, gate, warn_n});
    $display("test regs done");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    host.power_cycle();
    t_each_fault();
    t_regs();
    wrap_up();
  end
endmodule
